// [core/spwg_fifo.sv]
// Parameterised valid/ready FIFO that queues pulse instructions
`timescale 1ns/100ps
`default_nettype none
module spwg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,        // block clock
   input  wire logic             rst_in,        // async reset, active high
   input  wire logic             in_valid_in,   // word offered
   output logic                  in_ready_out,  // room for a word, registered
   input  wire logic [WIDTH-1:0] in_data_in,    // word to store
   output logic                  out_valid_out, // head word present
   input  wire logic             out_ready_in,  // reader takes head word
   output logic [WIDTH-1:0]      out_data_out   // head word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               count;
      logic                        ready;
   } spwg_fifo_state_t;

   localparam spwg_fifo_state_t FIFO_RESET = '{mem: '0, wr: '0, rd: '0, count: '0, ready: 1'b1};

   spwg_fifo_state_t st;
   spwg_fifo_state_t next_st;
   logic             push;
   logic             pop;

   assign out_valid_out = (st.count != '0);
   assign out_data_out  = st.mem[st.rd];
   assign in_ready_out  = st.ready;
   assign push          = in_valid_in && st.ready;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data_in;
         next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + PW'(1);
      end
      if (pop) begin
         next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + PW'(1);
      end
      next_st.count = st.count + CW'(push) - CW'(pop);
      // ready is registered so the filling side never sees a comb path
      next_st.ready = (next_st.count != CW'(DEPTH));
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= FIFO_RESET;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// [core/spwg_top.sv]
// Shaped-pulse waveform generator: package of constants and the top module
// Overview of operation
// - A zero shape enable sends the pulse unshaped, a nonzero one multiplies it by the envelope.
// - Each instruction selects an amplitude register whose constant scales its output.
// - Four writable amplitude registers give up to four output levels in one program.
// - A shaped pulse stretches the envelope across its whole duration; pulses under 64 cycles skip entries and end before the last one.
// - Carrier and envelope tables are both loadable through one load port.
// - The carrier table holds a sinewave after reset and loaded shapes replace it.
// - Pulse durations run from 80 ns (2 clock cycles, 66.6 ns rounded up) up to 693 days.
// - Legacy instructions run unshaped with amplitude register 0.
// - Converter sample strobes and a 10 MHz clock output are derived from the block clock.
package spwg_pkg;
   localparam int SMP_W      = 12;
   localparam int TBL_DEPTH  = 64;
   localparam int TBL_AW     = 6;
   localparam int JUMP_W     = TBL_AW + 1;
   localparam int ENV_W      = 13;
   localparam int ENV_FRAC   = 12;
   localparam logic [ENV_W-1:0] ENV_UNITY = 13'h1000;
   localparam logic [SMP_W-1:0] ENV_RESET = 12'hFFF;
   localparam int AMP_W      = 16;
   localparam int AMP_COUNT  = 4;
   localparam int AMP_SEL_W  = 2;
   localparam int AMP_FRAC   = 15;
   localparam logic [AMP_W-1:0] AMP_UNITY = 16'h8000;
   localparam int DAC_W      = 14;
   localparam int PHASE_W    = 32;
   localparam int DUR_W      = 51;
   localparam int ACC_W      = DUR_W + JUMP_W;
   // instruction word layout inside the queue
   localparam int IW_DUR_LSB    = 0;
   localparam int IW_AMP_LSB    = 51;
   localparam int IW_USE_BIT    = 53;
   localparam int IW_SHAPED_BIT = 54;
   localparam int IW_W          = 55;
   localparam int FIFO_DEPTH    = 8;
   // timing
   localparam longint CLOCK_HZ       = 25_000_000;
   localparam longint PS_PER_S       = 64'd1_000_000_000_000;
   localparam longint CLOCK_PERIOD_PS = PS_PER_S / CLOCK_HZ;
   localparam longint MIN_PULSE_PS   = 66_600;
   localparam longint MAX_PULSE_DAYS = 693;
   localparam longint SEC_PER_DAY    = 86_400;
   localparam logic [DUR_W-1:0] MIN_CYCLES =
      DUR_W'((MIN_PULSE_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
   localparam logic [DUR_W-1:0] MAX_CYCLES = DUR_W'(MAX_PULSE_DAYS * SEC_PER_DAY * CLOCK_HZ);
   // derived converter and reference rates
   localparam int CLOCK_MHZ   = 25;
   localparam int DAC_MHZ     = 300;
   localparam int ADC_MHZ     = 75;
   localparam int REF_OUT_MHZ = 10;
   localparam int ADC_DIV     = DAC_MHZ / ADC_MHZ;
   localparam int ADC_CW      = $clog2(ADC_DIV);
   localparam int REF_ACC_W   = $clog2(CLOCK_MHZ) + 1;
   localparam logic [REF_ACC_W-1:0] REF_STEP = REF_ACC_W'(2 * REF_OUT_MHZ);
   localparam logic [REF_ACC_W-1:0] REF_MOD  = REF_ACC_W'(CLOCK_MHZ);
   // first quarter of the default sine, full scale 0x7FF
   localparam int QTR = TBL_DEPTH / 4;
   localparam logic [QTR:0][SMP_W-1:0] SINE_QUARTER = {
      12'h7FF, 12'h7F5, 12'h7D8, 12'h7A7, 12'h763, 12'h70D, 12'h6A6, 12'h62E, 12'h5A7,
      12'h513, 12'h471, 12'h3C5, 12'h30F, 12'h252, 12'h18F, 12'h0C8, 12'h000};

   function automatic logic [TBL_DEPTH-1:0][SMP_W-1:0] sine_table();
      logic [TBL_DEPTH-1:0][SMP_W-1:0] t;
      logic [SMP_W-1:0]                v;
      int                              q;
      t = '0;
      for (int k = 0; k < TBL_DEPTH; k++) begin
         q = k % (2 * QTR);
         v = (q <= QTR) ? SINE_QUARTER[q] : SINE_QUARTER[2 * QTR - q];
         t[k] = (k < 2 * QTR) ? v : -v;
      end
      return t;
   endfunction

   localparam logic [TBL_DEPTH-1:0][SMP_W-1:0] CARRIER_RESET = sine_table();
   localparam logic [AMP_COUNT-1:0][AMP_W-1:0] AMP_RESET =
      {{((AMP_COUNT - 1) * AMP_W){1'b0}}, AMP_UNITY};

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } spwg_seq_t;

   typedef struct packed {
      spwg_seq_t                       seq;
      logic [TBL_DEPTH-1:0][SMP_W-1:0] carrier;
      logic [TBL_DEPTH-1:0][SMP_W-1:0] envelope;
      logic [AMP_COUNT-1:0][AMP_W-1:0] amp;
      logic                            carrier_loaded;
      logic [PHASE_W-1:0]              phase;
      logic [DUR_W-1:0]                dur;
      logic [DUR_W-1:0]                remain;
      logic [TBL_AW-1:0]               env_idx;
      logic [DUR_W-1:0]                env_rem;
      logic                            cur_shape;
      logic [AMP_SEL_W-1:0]            cur_amp;
      logic                            s1_valid;
      logic [SMP_W-1:0]                s1_car;
      logic [ENV_W-1:0]                s1_env;
      logic [AMP_W-1:0]                s1_amp;
      logic                            s2_valid;
      logic [SMP_W:0]                  s2_mix;
      logic [AMP_W-1:0]                s2_amp;
      logic [DAC_W-1:0]                dac;
      logic                            dac_valid;
      logic [ADC_CW-1:0]               adc_cnt;
      logic                            adc_en;
      logic [REF_ACC_W-1:0]            ref_acc;
      logic                            ref_clk;
   } spwg_state_t;

   localparam spwg_state_t STATE_RESET = '{seq: ST_IDLE, carrier: CARRIER_RESET,
      envelope: {TBL_DEPTH{ENV_RESET}}, amp: AMP_RESET, default: '0};
endpackage

`timescale 1ns/100ps
`default_nettype none
module spwg_top #(
   parameter logic [spwg_pkg::DUR_W-1:0] MAX_DURATION_CYCLES = spwg_pkg::MAX_CYCLES
) (
   input  wire logic                           CLOCK_IN,          // 25 MHz block clock
   input  wire logic                           RESET_IN,          // async reset, active high
   input  wire logic                           INSTR_VALID_IN,    // instruction offered
   output logic                                INSTR_READY_OUT,   // queue has room
   input  wire logic                           INSTR_SHAPED_IN,   // 1 shaped format, 0 legacy
   input  wire logic                           INSTR_USE_SHAPE_IN,// nonzero shape enable
   input  wire logic [spwg_pkg::AMP_SEL_W-1:0] INSTR_AMP_SEL_IN,  // amplitude register pick
   input  wire logic [spwg_pkg::DUR_W-1:0]     INSTR_DURATION_IN, // length in clock cycles
   input  wire logic [spwg_pkg::PHASE_W-1:0]   FREQ_WORD_IN,      // carrier phase step
   input  wire logic                           AMP_WRITE_IN,      // amplitude value write
   input  wire logic [spwg_pkg::AMP_SEL_W-1:0] AMP_INDEX_IN,      // register written
   input  wire logic [spwg_pkg::AMP_W-1:0]     AMP_VALUE_IN,      // gain, 0x8000 is 1.0
   input  wire logic                           LOAD_WRITE_IN,     // table load strobe
   input  wire logic                           LOAD_ENVELOPE_IN,  // 1 envelope, 0 carrier
   input  wire logic [spwg_pkg::TBL_AW-1:0]    LOAD_ADDR_IN,      // table entry
   input  wire logic [spwg_pkg::SMP_W-1:0]     LOAD_DATA_IN,      // table sample
   output logic [spwg_pkg::DAC_W-1:0]          DAC_SAMPLE_OUT,    // signed output sample
   output logic                                DAC_VALID_OUT,     // sample belongs to a pulse
   output logic                                ADC_SAMPLE_EN_OUT, // input converter strobe
   output logic                                REF_CLOCK_OUT      // 10 MHz reference out
);
   import spwg_pkg::*;

   spwg_state_t             st;
   spwg_state_t             next_st;
   logic                    fifo_valid;
   logic                    fifo_ready;
   logic [IW_W-1:0]         fifo_word;
   logic                    load;
   logic [ACC_W-1:0]        acc;
   logic [JUMP_W-1:0]       jump;
   logic [JUMP_W:0]         idx_sum;
   logic [DUR_W-1:0]        dur_clamp;
   logic [REF_ACC_W:0]      ref_sum;
   logic signed [SMP_W+ENV_W:0]      prod1;
   logic signed [SMP_W+AMP_W+1:0]    prod2;

   spwg_fifo #(
      .WIDTH(IW_W),
      .DEPTH(FIFO_DEPTH)
   ) u_spwg_fifo (
      .clk_in       (CLOCK_IN),
      .rst_in       (RESET_IN),
      .in_valid_in  (INSTR_VALID_IN),
      .in_ready_out (INSTR_READY_OUT),
      .in_data_in   ({INSTR_SHAPED_IN, INSTR_USE_SHAPE_IN, INSTR_AMP_SEL_IN, INSTR_DURATION_IN}),
      .out_valid_out(fifo_valid),
      .out_ready_in (fifo_ready),
      .out_data_out (fifo_word)
   );

   // next instruction is taken on the last cycle of the current one: no gap
   assign fifo_ready = (st.seq == ST_IDLE) || (st.remain == DUR_W'(1));
   assign load       = fifo_valid && fifo_ready;

   always_comb begin
      next_st   = st;
      acc       = '0;
      jump      = '0;
      idx_sum   = '0;
      dur_clamp = '0;
      ref_sum   = '0;
      prod1     = '0;
      prod2     = '0;

      if (AMP_WRITE_IN) begin
         next_st.amp[AMP_INDEX_IN] = AMP_VALUE_IN;
      end
      if (LOAD_WRITE_IN) begin
         if (LOAD_ENVELOPE_IN) begin
            next_st.envelope[LOAD_ADDR_IN] = LOAD_DATA_IN;
         end else begin
            next_st.carrier[LOAD_ADDR_IN] = LOAD_DATA_IN;
            next_st.carrier_loaded = 1'b1;
         end
      end

      // rate strobes: one sample per clock stands in for the output converter
      next_st.adc_en = (st.adc_cnt == ADC_CW'(ADC_DIV - 1));
      next_st.adc_cnt = next_st.adc_en ? '0 : st.adc_cnt + ADC_CW'(1);
      // fractional divider, average 10 MHz with one-cycle jitter
      ref_sum = {1'b0, st.ref_acc} + {1'b0, REF_STEP};
      if (ref_sum >= {1'b0, REF_MOD}) begin
         next_st.ref_acc = REF_ACC_W'(ref_sum - {1'b0, REF_MOD});
         next_st.ref_clk = ~st.ref_clk;
      end else begin
         next_st.ref_acc = REF_ACC_W'(ref_sum);
      end

      next_st.phase = st.phase + FREQ_WORD_IN;

      // stage 1: fetch carrier, envelope factor and gain for this cycle
      next_st.s1_valid = (st.seq == ST_RUN);
      next_st.s1_car = st.carrier[st.phase[PHASE_W-1 -: TBL_AW]];
      next_st.s1_env = st.cur_shape ? {1'b0, st.envelope[st.env_idx]} : ENV_UNITY;
      next_st.s1_amp = st.amp[st.cur_amp];

      // stage 2 and 3: carrier x envelope, then x gain
      next_st.s2_valid = st.s1_valid;
      prod1 = $signed(st.s1_car) * $signed({1'b0, st.s1_env});
      next_st.s2_mix = prod1[ENV_FRAC +: SMP_W + 1];
      next_st.s2_amp = st.s1_amp;
      prod2 = $signed(st.s2_mix) * $signed({1'b0, st.s2_amp});
      // gain below 2.0 keeps the product inside 14 bits, no saturation needed
      next_st.dac = st.s2_valid ? prod2[AMP_FRAC +: DAC_W] : '0;
      next_st.dac_valid = st.s2_valid;

      unique case (st.seq)
         ST_IDLE: begin
            next_st.remain = '0;
         end
         ST_RUN: begin
            next_st.remain = st.remain - DUR_W'(1);
            // index = floor(elapsed * depth / duration); short pulses skip entries
            acc = ACC_W'(st.env_rem) + ACC_W'(TBL_DEPTH);
            for (int m = 1; m <= TBL_DEPTH; m++) begin
               if (acc >= ACC_W'(m) * ACC_W'(st.dur)) begin
                  jump = JUMP_W'(m);
               end
            end
            next_st.env_rem = DUR_W'(acc - ACC_W'(jump) * ACC_W'(st.dur));
            idx_sum = {2'b00, st.env_idx} + {1'b0, jump};
            next_st.env_idx = (idx_sum > (JUMP_W + 1)'(TBL_DEPTH - 1)) ?
               TBL_AW'(TBL_DEPTH - 1) : idx_sum[TBL_AW-1:0];
            if (st.remain == DUR_W'(1)) begin
               next_st.seq = ST_IDLE;
            end
         end
      endcase

      if (load) begin
         dur_clamp = fifo_word[IW_DUR_LSB +: DUR_W];
         if (dur_clamp < MIN_CYCLES) begin
            dur_clamp = MIN_CYCLES;
         end else if (dur_clamp > MAX_DURATION_CYCLES) begin
            dur_clamp = MAX_DURATION_CYCLES;
         end
         next_st.seq = ST_RUN;
         next_st.dur = dur_clamp;
         next_st.remain = dur_clamp;
         next_st.env_idx = '0;
         next_st.env_rem = '0;
         // legacy words carry no shape fields
         next_st.cur_shape = fifo_word[IW_SHAPED_BIT] && fifo_word[IW_USE_BIT];
         next_st.cur_amp = fifo_word[IW_SHAPED_BIT] ? fifo_word[IW_AMP_LSB +: AMP_SEL_W] : '0;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign DAC_SAMPLE_OUT    = st.dac;
   assign DAC_VALID_OUT     = st.dac_valid;
   assign ADC_SAMPLE_EN_OUT = st.adc_en;
   assign REF_CLOCK_OUT     = st.ref_clk;

   // checking helpers
   logic [AMP_W-1:0]         sel_amp;
   logic [SMP_W-1:0]         sel_env;
   logic signed [SMP_W:0]    chk_mix;
   logic signed [DAC_W-1:0]  chk_out;
   logic signed [SMP_W+ENV_W:0]   chk_p1;
   logic signed [SMP_W+AMP_W+1:0] chk_p2;
   assign sel_amp = st.amp[st.cur_amp];
   assign sel_env = st.envelope[st.env_idx];
   assign chk_p1  = $signed(st.s1_car) * $signed({1'b0, st.s1_env});
   assign chk_mix = chk_p1[ENV_FRAC +: SMP_W + 1];
   assign chk_p2  = chk_mix * $signed({1'b0, st.s1_amp});
   assign chk_out = chk_p2[AMP_FRAC +: DAC_W];

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RESET_IN);

   property p_unshaped;
      (st.seq == ST_RUN && !st.cur_shape) |=> st.s1_valid && st.s1_env == ENV_UNITY;
   endproperty
   a_unshaped: assert property (p_unshaped)
      else $error("unshaped pulse did not use unity envelope");
   property p_shaped;
      (st.seq == ST_RUN && st.cur_shape) |=> st.s1_env == {1'b0, $past(sel_env)};
   endproperty
   a_shaped: assert property (p_shaped)
      else $error("shaped pulse did not use loaded envelope");
   property p_amp_pick;
      (st.seq == ST_RUN) |=> st.s1_amp == $past(sel_amp);
   endproperty
   a_amp_pick: assert property (p_amp_pick)
      else $error("wrong amplitude register applied");
   property p_amp_write;
      AMP_WRITE_IN |=> st.amp[$past(AMP_INDEX_IN)] == $past(AMP_VALUE_IN);
   endproperty
   a_amp_write: assert property (p_amp_write)
      else $error("amplitude register write lost");
   property p_stretch_end;
      (st.seq == ST_RUN && st.remain == DUR_W'(1) && st.dur >= DUR_W'(TBL_DEPTH))
         |-> st.env_idx == TBL_AW'(TBL_DEPTH - 1);
   endproperty
   a_stretch_end: assert property (p_stretch_end)
      else $error("envelope did not reach last entry at pulse end");
   property p_stretch_start;
      load |=> st.env_idx == '0 && st.env_rem == '0;
   endproperty
   a_stretch_start: assert property (p_stretch_start)
      else $error("envelope did not restart at pulse start");
   property p_env_load;
      (LOAD_WRITE_IN && LOAD_ENVELOPE_IN)
         |=> st.envelope[$past(LOAD_ADDR_IN)] == $past(LOAD_DATA_IN);
   endproperty
   a_env_load: assert property (p_env_load)
      else $error("envelope table write lost");
   property p_sine_default;
      !st.carrier_loaded |-> st.carrier == CARRIER_RESET;
   endproperty
   a_sine_default: assert property (p_sine_default)
      else $error("carrier table not the default sine");
   property p_duration;
      load |=> st.remain >= MIN_CYCLES && st.remain <= MAX_DURATION_CYCLES && st.seq == ST_RUN;
   endproperty
   a_duration: assert property (p_duration)
      else $error("pulse duration out of range");
   property p_legacy;
      (load && !fifo_word[IW_SHAPED_BIT]) |=> !st.cur_shape && st.cur_amp == '0;
   endproperty
   a_legacy: assert property (p_legacy)
      else $error("legacy instruction not unshaped on register 0");
   property p_adc_rate;
      ADC_SAMPLE_EN_OUT |=> !ADC_SAMPLE_EN_OUT [*3] ##1 ADC_SAMPLE_EN_OUT;
   endproperty
   a_adc_rate: assert property (p_adc_rate)
      else $error("input converter strobe off rate");
   property p_ref_clock;
      // divider phase restarts with reset, so the edges just after it carry no verdict
      (!$past(RESET_IN) && $stable(REF_CLOCK_OUT)) |=> $changed(REF_CLOCK_OUT);
   endproperty
   a_ref_clock: assert property (p_ref_clock)
      else $error("reference output held too long");
   property p_sample;
      st.s1_valid |-> ##2 DAC_VALID_OUT && $signed(DAC_SAMPLE_OUT) == $past(chk_out, 2);
   endproperty
   a_sample: assert property (p_sample)
      else $error("output sample not carrier x envelope x gain");

   c_shaped: cover property (load && fifo_word[IW_SHAPED_BIT] && fifo_word[IW_USE_BIT]);
   c_legacy: cover property (load && !fifo_word[IW_SHAPED_BIT]);
   c_back_to_back: cover property (load && st.seq == ST_RUN);
   c_queue_full: cover property (!INSTR_READY_OUT);
endmodule
`default_nettype wire

// [testbench/spwg_host_model.sv]
// Partner model: pulse-program sequencer and host table loader
`timescale 1ns/100ps
`default_nettype none
module spwg_host_model (
   input  wire logic                      clk_in,        // block clock
   input  wire logic                      ready_in,      // queue has room
   output logic                           valid_out,     // instruction offered
   output logic                           shaped_out,    // shaped format
   output logic                           use_shape_out, // shape enable
   output logic [spwg_pkg::AMP_SEL_W-1:0] amp_sel_out,   // amplitude pick
   output logic [spwg_pkg::DUR_W-1:0]     dur_out,       // length in cycles
   output logic                           amp_wr_out,    // amplitude value write
   output logic [spwg_pkg::AMP_SEL_W-1:0] amp_idx_out,   // register written
   output logic [spwg_pkg::AMP_W-1:0]     amp_val_out,   // gain
   output logic                           load_wr_out,   // table load strobe
   output logic                           load_env_out,  // 1 envelope, 0 carrier
   output logic [spwg_pkg::TBL_AW-1:0]    load_addr_out, // table entry
   output logic [spwg_pkg::SMP_W-1:0]     load_data_out  // table sample
);
   import spwg_pkg::*;
   initial begin
      {valid_out, shaped_out, use_shape_out, amp_sel_out, dur_out} = '0;
      {amp_wr_out, amp_idx_out, amp_val_out} = '0;
      {load_wr_out, load_env_out, load_addr_out, load_data_out} = '0;
   end
   // released fields flip so a stale word is never mistaken for a fresh one
   task automatic idle();
      valid_out <= 1'b0;
      {shaped_out, use_shape_out, amp_sel_out} <= ~{shaped_out, use_shape_out, amp_sel_out};
      dur_out <= ~dur_out;
   endtask
   task automatic send(input logic sh, input logic us, input logic [1:0] a,
                       input logic [50:0] d, input int gap);
      int n;
      if (gap > 0) begin
         idle();
         repeat (gap) @(posedge clk_in);
      end
      valid_out <= 1'b1;
      {shaped_out, use_shape_out, amp_sel_out, dur_out} <= {sh, us, a, d};
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (ready_in !== 1'b1 && n < 5000);
   endtask
   task automatic load(input logic env, input logic [5:0] ad, input logic [11:0] dt);
      {load_wr_out, load_env_out, load_addr_out, load_data_out} <= {1'b1, env, ad, dt};
      @(posedge clk_in);
      load_wr_out <= 1'b0;
      load_data_out <= ~dt;
      @(posedge clk_in);
   endtask
   task automatic amp_write(input logic [1:0] i, input logic [15:0] v);
      {amp_wr_out, amp_idx_out, amp_val_out} <= {1'b1, i, v};
      @(posedge clk_in);
      amp_wr_out <= 1'b0;
      amp_val_out <= ~v;
      @(posedge clk_in);
   endtask
   task automatic default_init();
      amp_write(2'h0, AMP_UNITY);
   endtask
endmodule
`default_nettype wire

// [testbench/tb_shaped_pulse_waveform_gen.sv]
// Self-checking bench for the shaped-pulse waveform generator
`timescale 1ns/100ps
`default_nettype none
module tb_shaped_pulse_waveform_gen;
   import spwg_pkg::*;
   logic clk = 1'b0;
   logic rst, valid, ready, shaped, use_sh, amp_wr, load_wr, load_env, dac_valid, adc_en, ref_clk;
   logic [1:0]  amp_sel, amp_idx;
   logic [50:0] dur;
   logic [31:0] freq;
   logic [15:0] amp_val;
   logic [5:0]  load_addr;
   logic [11:0] load_data;
   logic [13:0] dac;
   logic [13:0] got[$];
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   spwg_top #(.MAX_DURATION_CYCLES(51'hC8)) u_spwg_top (.CLOCK_IN(clk), .RESET_IN(rst),
      .INSTR_VALID_IN(valid), .INSTR_READY_OUT(ready), .INSTR_SHAPED_IN(shaped),
      .INSTR_USE_SHAPE_IN(use_sh), .INSTR_AMP_SEL_IN(amp_sel), .INSTR_DURATION_IN(dur),
      .FREQ_WORD_IN(freq), .AMP_WRITE_IN(amp_wr), .AMP_INDEX_IN(amp_idx),
      .AMP_VALUE_IN(amp_val), .LOAD_WRITE_IN(load_wr), .LOAD_ENVELOPE_IN(load_env),
      .LOAD_ADDR_IN(load_addr), .LOAD_DATA_IN(load_data), .DAC_SAMPLE_OUT(dac),
      .DAC_VALID_OUT(dac_valid), .ADC_SAMPLE_EN_OUT(adc_en), .REF_CLOCK_OUT(ref_clk));
   spwg_host_model u_spwg_host_model (.clk_in(clk), .ready_in(ready), .valid_out(valid),
      .shaped_out(shaped), .use_shape_out(use_sh), .amp_sel_out(amp_sel), .dur_out(dur),
      .amp_wr_out(amp_wr), .amp_idx_out(amp_idx), .amp_val_out(amp_val),
      .load_wr_out(load_wr), .load_env_out(load_env), .load_addr_out(load_addr),
      .load_data_out(load_data));
   always @(posedge clk) if (dac_valid === 1'b1) got.push_back(dac);
   task automatic report_and_stop();
      if (fails == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [50:0] exp, input logic [50:0] seen);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // pulse starts 4 edges after the push, then wait out the valid window
   task automatic wait_done();
      int n;
      u_spwg_host_model.idle();
      repeat (6) @(posedge clk);
      n = 0;
      while (dac_valid !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   task automatic t_clocks();
      int a, r;
      logic rq;
      a = 0;
      r = 0;
      @(posedge clk);
      rq = ref_clk;
      repeat (100) begin
         @(posedge clk);
         if (adc_en === 1'b1) a++;
         if (ref_clk !== rq) r++;
         rq = ref_clk;
      end
      chk("adc_strobes", 51'h19, a);
      chk("ref_toggles", 51'h50, r);
   endtask
   // quarter-turn phase steps visit entries 0, 16, 32 and 48 of the default sine
   task automatic t_sine();
      int bad, peak;
      bad = 0;
      peak = 0;
      got.delete();
      u_spwg_host_model.send(1'b0, 1'b0, 2'h0, 51'h10, 0);
      wait_done();
      foreach (got[i]) begin
         if (got[i] === 14'h07FF) peak++;
         else if (got[i] !== 14'h0000 && got[i] !== 14'h3801) bad++;
      end
      chk("sine_count", 51'h10, got.size());
      chk("sine_peaks", 51'h4, peak);
      chk("sine_other", 51'h0, bad);
   endtask
   task automatic t_amp();
      logic [13:0] e[5];
      e = '{14'h0400, 14'h0400, 14'h0200, 14'h0100, 14'h0300};
      freq <= 32'h0;
      for (int k = 0; k < 64; k++) u_spwg_host_model.load(1'b0, 6'(k), 12'h400);
      u_spwg_host_model.default_init();
      u_spwg_host_model.amp_write(2'h1, 16'h4000);
      u_spwg_host_model.amp_write(2'h2, 16'h2000);
      u_spwg_host_model.amp_write(2'h3, 16'h6000);
      got.delete();
      u_spwg_host_model.send(1'b0, 1'b1, 2'h3, 51'h3, 0);
      for (int a = 0; a < 4; a++) u_spwg_host_model.send(1'b1, 1'b0, 2'(a), 51'h3, 0);
      wait_done();
      chk("amp_count", 51'hF, got.size());
      for (int i = 0; i < 15; i++) chk("amp_sample", e[i / 3], got[i]);
   endtask
   task automatic t_env();
      for (int k = 0; k < 64; k++) u_spwg_host_model.load(1'b1, 6'(k), 12'(k * 64));
      got.delete();
      u_spwg_host_model.send(1'b1, 1'b1, 2'h0, 51'h80, 0);
      u_spwg_host_model.send(1'b1, 1'b1, 2'h0, 51'h20, 0);
      wait_done();
      chk("env_count", 51'hA0, got.size());
      for (int e = 0; e < 160; e++)
         chk("env_sample", (e < 128) ? 51'((e / 2) * 16) : 51'((e - 128) * 32), got[e]);
   endtask
   task automatic t_limits();
      got.delete();
      u_spwg_host_model.send(1'b0, 1'b0, 2'h0, 51'h1, 3);
      u_spwg_host_model.send(1'b0, 1'b0, 2'h0, 51'h12C, 3);
      wait_done();
      chk("clamp_count", 51'hCA, got.size());
   endtask
   task automatic t_fill();
      got.delete();
      for (int i = 0; i < 9; i++) u_spwg_host_model.send(1'b0, 1'b0, 2'h0, 51'h32, 0);
      u_spwg_host_model.idle();
      repeat (2) @(posedge clk);
      chk("queue_full", 51'h0, ready);
      wait_done();
      chk("queue_drain", 51'h1C2, got.size());
      chk("queue_empty", 51'h1, ready);
   endtask
   initial begin
      rst = 1'b1;
      freq = 32'h4000_0000;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_clocks();
      t_sine();
      t_amp();
      t_env();
      t_limits();
      t_fill();
      report_and_stop();
   end
endmodule
`default_nettype wire
